// file: adc_config_regs.sv
/*
  Configuration register block: serial port slave, triplicated registers,
  radiation guard, calibration load with CRC, and sync pulse gating.
  Assumes all inputs synchronous to clock; serial clock sampled as data.
*/
module adc_config_regs #(
  parameter int ADDR_W = 7
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Serial configuration port
  input wire logic serial_clk,
  input wire logic serial_cs_n,
  input wire logic serial_mosi,
  output logic serial_miso,
  output logic serial_miso_oe,
  // Factory calibration storage: a_hot, a_cold, b_hot, b_cold
  input wire adc_regs_pkg::factory_set_t [3:0] factory_cal,
  // Sync input and timing reset
  input wire logic sync_trigger_input,
  output logic timing_reset,
  // Core controls
  output adc_regs_pkg::channel_trim_t trim_a,
  output adc_regs_pkg::channel_trim_t trim_b,
  output logic clock_interleave_bit,
  output logic cal_select,
  output logic trigger_enable_bit,
  output logic sync_out_full_swing,
  output logic radiation_guard_bit
);

  if (ADDR_W != 7) begin : g_check
    $error("ADDR_W must be 7");
  end

  // ****************************************
  // Serial port
  // ****************************************
  logic sclk_prev_reg, sclk_prev_next;
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [22:0] shift_in_reg, shift_in_next;
  logic [15:0] shift_out_reg, shift_out_next;
  logic is_read_reg, is_read_next;
  logic [6:0] addr_reg, addr_next;
  logic sclk_rise, sclk_fall;
  logic [7:0] header;
  logic [15:0] wdata;
  logic frame_write;
  logic wr_strobe;
  logic load_strobe;
  logic [15:0] rw_value [adc_regs_pkg::NUM_RW];

  assign sclk_rise = serial_clk && !sclk_prev_reg && !serial_cs_n;
  assign sclk_fall = !serial_clk && sclk_prev_reg && !serial_cs_n;
  assign header = {shift_in_reg[6:0], serial_mosi};
  assign wdata = {shift_in_reg[14:0], serial_mosi};
  assign frame_write = sclk_rise && (bit_cnt_reg == 5'h17) && !is_read_reg;
  // Guard register itself stays writable so software can clear it
  assign wr_strobe = frame_write && (!radiation_guard_bit ||
    addr_reg == adc_regs_pkg::ADDR_GUARD);
  assign load_strobe = frame_write && !radiation_guard_bit &&
    addr_reg == adc_regs_pkg::ADDR_LOAD_CAL && wdata[adc_regs_pkg::BIT_LOAD_CAL];

  always_comb begin
    sclk_prev_next = serial_clk;
    bit_cnt_next = bit_cnt_reg;
    shift_in_next = shift_in_reg;
    shift_out_next = shift_out_reg;
    is_read_next = is_read_reg;
    addr_next = addr_reg;
    if (serial_cs_n) begin
      bit_cnt_next = 5'h00;
      shift_out_next = 16'h0000;
    end else if (sclk_rise) begin
      shift_in_next = {shift_in_reg[21:0], serial_mosi};
      if (bit_cnt_reg != 5'h18) begin
        bit_cnt_next = bit_cnt_reg + 5'h01;
      end
      if (bit_cnt_reg == 5'h07) begin
        is_read_next = header[7];
        addr_next = header[6:0];
        shift_out_next = rdata_of(header[6:0]);
      end
    end else if (sclk_fall && bit_cnt_reg > 5'h08) begin
      shift_out_next = {shift_out_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sclk_prev_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      shift_in_reg <= 23'h000000;
      shift_out_reg <= 16'h0000;
      is_read_reg <= 1'b0;
      addr_reg <= 7'h00;
    end else begin
      sclk_prev_reg <= sclk_prev_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_in_reg <= shift_in_next;
      shift_out_reg <= shift_out_next;
      is_read_reg <= is_read_next;
      addr_reg <= addr_next;
    end
  end

  assign serial_miso = shift_out_reg[15];
  assign serial_miso_oe = !serial_cs_n;

  // ****************************************
  // Read decode
  // ****************************************
  logic [15:0] crc_a_reg, crc_a_next;
  logic [15:0] crc_b_reg, crc_b_next;

  function automatic logic [15:0] rdata_of(input logic [6:0] a);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < adc_regs_pkg::NUM_RW; i++) begin
      if (a == adc_regs_pkg::RW_ADDR[i]) begin
        r = rw_value[i];
      end
    end
    case (a)
      adc_regs_pkg::ADDR_CRC_A: r = crc_a_reg;
      adc_regs_pkg::ADDR_CRC_B: r = crc_b_reg;
      adc_regs_pkg::ADDR_REF_A_HOT: r = factory_cal[0].ref_crc;
      adc_regs_pkg::ADDR_REF_A_COLD: r = factory_cal[1].ref_crc;
      adc_regs_pkg::ADDR_REF_B_HOT: r = factory_cal[2].ref_crc;
      adc_regs_pkg::ADDR_REF_B_COLD: r = factory_cal[3].ref_crc;
      default: r = r;
    endcase
    return r;
  endfunction

  // ****************************************
  // Triplicated registers
  // ****************************************
  adc_regs_pkg::factory_set_t set_a, set_b;
  logic [15:0] load_word [adc_regs_pkg::NUM_RW];
  logic load_hit [adc_regs_pkg::NUM_RW];

  assign set_a = factory_cal[{1'b0, cal_select}];
  assign set_b = factory_cal[{1'b1, cal_select}];

  always_comb begin
    for (int i = 0; i < adc_regs_pkg::NUM_RW; i++) begin
      load_word[i] = wdata & adc_regs_pkg::RW_MASK[i];
      load_hit[i] = wr_strobe && addr_reg == adc_regs_pkg::RW_ADDR[i];
    end
    if (load_strobe) begin
      load_word[adc_regs_pkg::IDX_GAIN_A] = {6'h00, set_a.gain};
      load_word[adc_regs_pkg::IDX_PHASE_A] = {8'h00, set_a.phase};
      load_word[adc_regs_pkg::IDX_OFFSET_A] = {7'h00, set_a.offset};
      load_word[adc_regs_pkg::IDX_GAIN_B] = {6'h00, set_b.gain};
      load_word[adc_regs_pkg::IDX_PHASE_B] = {8'h00, set_b.phase};
      load_word[adc_regs_pkg::IDX_OFFSET_B] = {7'h00, set_b.offset};
      load_hit[adc_regs_pkg::IDX_GAIN_A] = 1'b1;
      load_hit[adc_regs_pkg::IDX_PHASE_A] = 1'b1;
      load_hit[adc_regs_pkg::IDX_OFFSET_A] = 1'b1;
      load_hit[adc_regs_pkg::IDX_GAIN_B] = 1'b1;
      load_hit[adc_regs_pkg::IDX_PHASE_B] = 1'b1;
      load_hit[adc_regs_pkg::IDX_OFFSET_B] = 1'b1;
    end
  end

  for (genvar g = 0; g < adc_regs_pkg::NUM_RW; g++) begin : g_reg
    tmr_cell #(
      .WIDTH(16),
      .RESET_VALUE(adc_regs_pkg::RW_RESET[g])
    ) u_cell (
      .clock(clock),
      .reset_n(reset_n),
      .load(load_hit[g]),
      .load_value(load_word[g]),
      .refresh(sclk_rise),
      .value(rw_value[g])
    );
  end

  // ****************************************
  // Field outputs
  // ****************************************
  assign clock_interleave_bit = rw_value[adc_regs_pkg::IDX_CHIP][adc_regs_pkg::BIT_INTERLEAVE];
  assign cal_select = rw_value[adc_regs_pkg::IDX_CHIP][adc_regs_pkg::BIT_CAL_SELECT];
  assign trigger_enable_bit = rw_value[adc_regs_pkg::IDX_CHIP][adc_regs_pkg::BIT_TRIGGER_ENABLE];
  assign sync_out_full_swing = rw_value[adc_regs_pkg::IDX_CHIP][adc_regs_pkg::BIT_FULL_SWING];
  assign radiation_guard_bit = rw_value[adc_regs_pkg::IDX_GUARD][adc_regs_pkg::BIT_GUARD];

  always_comb begin
    trim_a.delay_disable = rw_value[adc_regs_pkg::IDX_DELAY_A][adc_regs_pkg::BIT_DELAY_DISABLE];
    trim_a.delay_value = rw_value[adc_regs_pkg::IDX_DELAY_A][9:0];
    trim_a.gain = rw_value[adc_regs_pkg::IDX_GAIN_A][9:0];
    trim_a.phase = rw_value[adc_regs_pkg::IDX_PHASE_A][7:0];
    trim_a.offset = rw_value[adc_regs_pkg::IDX_OFFSET_A][8:0];
    trim_b.delay_disable = rw_value[adc_regs_pkg::IDX_DELAY_B][adc_regs_pkg::BIT_DELAY_DISABLE];
    trim_b.delay_value = rw_value[adc_regs_pkg::IDX_DELAY_B][9:0];
    trim_b.gain = rw_value[adc_regs_pkg::IDX_GAIN_B][9:0];
    trim_b.phase = rw_value[adc_regs_pkg::IDX_PHASE_B][7:0];
    trim_b.offset = rw_value[adc_regs_pkg::IDX_OFFSET_B][8:0];
  end

  // ****************************************
  // Calibration CRC and sync gating
  // ****************************************
  logic timing_reset_reg, timing_reset_next;

  function automatic logic [15:0] crc_of(input adc_regs_pkg::factory_set_t s);
    logic [26:0] d;
    logic [15:0] c;
    d = {s.gain, s.phase, s.offset};
    c = adc_regs_pkg::CRC_INIT;
    for (int i = 26; i >= 0; i--) begin
      c = c[15] ^ d[i] ? {c[14:0], 1'b0} ^ adc_regs_pkg::CRC_POLY : {c[14:0], 1'b0};
    end
    return c;
  endfunction

  always_comb begin
    crc_a_next = load_strobe ? crc_of(set_a) : crc_a_reg;
    crc_b_next = load_strobe ? crc_of(set_b) : crc_b_reg;
    timing_reset_next = sync_trigger_input && !trigger_enable_bit &&
      !radiation_guard_bit;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      crc_a_reg <= 16'h0000;
      crc_b_reg <= 16'h0000;
      timing_reset_reg <= 1'b0;
    end else begin
      crc_a_reg <= crc_a_next;
      crc_b_reg <= crc_b_next;
      timing_reset_reg <= timing_reset_next;
    end
  end

  assign timing_reset = timing_reset_reg;

  // ****************************************
  // Checks
  // ****************************************
  guard_blocks_sync_a: assert property (@(posedge clock) disable iff (!reset_n)
    (radiation_guard_bit && sync_trigger_input) |=> !timing_reset)
    else $error("sync passed while guarded");

  sync_resets_timing_a: assert property (@(posedge clock) disable iff (!reset_n)
    (!radiation_guard_bit && !trigger_enable_bit && sync_trigger_input) |=> timing_reset)
    else $error("sync pulse lost in sync mode");

  guard_freezes_regs_a: assert property (@(posedge clock) disable iff (!reset_n)
    (radiation_guard_bit && frame_write && addr_reg != adc_regs_pkg::ADDR_GUARD)
    |=> $stable(trim_a) && $stable(trim_b) && $stable(clock_interleave_bit))
    else $error("register changed while guarded");

  reset_defaults_a: assert property (@(posedge clock)
    $rose(reset_n) |-> trim_a.offset == 9'h100 && trim_b.gain == 10'h200 &&
    trim_a.phase == 8'h80 && trim_b.delay_disable && clock_interleave_bit &&
    !radiation_guard_bit)
    else $error("wrong reset defaults");

  crc_read_only_a: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_strobe && (addr_reg == adc_regs_pkg::ADDR_CRC_A)) |=> $stable(crc_a_reg))
    else $error("computed CRC overwritten");

  cal_load_copy_a: assert property (@(posedge clock) disable iff (!reset_n)
    load_strobe |=> trim_a.gain == $past(set_a.gain) && trim_b.offset == $past(set_b.offset)
    && crc_a_reg == $past(crc_of(set_a)))
    else $error("calibration set not loaded");

  interleave_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_strobe && addr_reg == adc_regs_pkg::ADDR_CHIP_CONTROL)
    |=> clock_interleave_bit == $past(wdata[0]))
    else $error("interleave bit not written");

  guard_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    (frame_write && addr_reg == adc_regs_pkg::ADDR_GUARD)
    |=> radiation_guard_bit == $past(wdata[0]))
    else $error("guard bit write lost");

  offset_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_strobe && addr_reg == adc_regs_pkg::ADDR_OFFSET_A)
    |=> trim_a.offset == $past(wdata[8:0]))
    else $error("offset trim not written");

  gain_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_strobe && addr_reg == adc_regs_pkg::ADDR_GAIN_B)
    |=> trim_b.gain == $past(wdata[9:0]))
    else $error("gain trim not written");

  phase_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_strobe && addr_reg == adc_regs_pkg::ADDR_PHASE_B)
    |=> trim_b.phase == $past(wdata[7:0]))
    else $error("phase trim not written");

  delay_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_strobe && addr_reg == adc_regs_pkg::ADDR_DELAY_A)
    |=> trim_a.delay_disable == $past(wdata[12]) && trim_a.delay_value == $past(wdata[9:0]))
    else $error("fine delay not written");

  crc_readout_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sclk_rise && bit_cnt_reg == 5'h07 && header == {1'b1, adc_regs_pkg::ADDR_CRC_B})
    |=> shift_out_reg == $past(crc_b_reg))
    else $error("computed CRC not read out");

endmodule // adc_config_regs

// file: adc_regs_pkg.sv
/*
  Constants, register map and carrier types for the converter's
  configuration register block.
  Assumes one synchronous clock domain and a serial configuration port.
*/
// Functional notes
// - Guard bit set masks sync pulses in synchronization mode.
// - Guard bit set blocks every configuration register change except writes to the guard register at 0x7F.
// - Each rising serial clock edge with chip select low refreshes all triplicated copies, clearing upsets.
// - Factory reference CRCs readable at 0x76 to 0x79.
// - Loading a calibration set computes its CRC per channel, read at 0x69/0x6A.
// - Interleave bit zero gives in-phase clocks, one opposite; default one.
// - Nine-bit offset trim, bits 8 to 0, at 0x23 and 0x42.
// - Offset trim resets to 0x100; 0x000 most positive, 0x1FF most negative.
// - Ten-bit gain trim at 0x21 and 0x40, reset 0x200.
// - Eight-bit phase trim in low bits at 0x22 and 0x41.
// - Phase trim resets to 0x80; 0x00 most negative, 0xFF most positive.
// - Fine delay offers 1024 codes of 10 fs, per channel.
// - Fine delay control at 0x20 for A, 0x3F for B.
// - Fine delay disabled while bit 12 is one, the default.
// - Trigger-enable zero selects synchronization mode; sync pulse resets timing.
// - Writing one to bit 0 at 0x7E loads the selected factory set.
package adc_regs_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [6:0] ADDR_CHIP_CONTROL = 7'h04;
  localparam logic [6:0] ADDR_DELAY_A = 7'h20;
  localparam logic [6:0] ADDR_GAIN_A = 7'h21;
  localparam logic [6:0] ADDR_PHASE_A = 7'h22;
  localparam logic [6:0] ADDR_OFFSET_A = 7'h23;
  localparam logic [6:0] ADDR_DELAY_B = 7'h3F;
  localparam logic [6:0] ADDR_GAIN_B = 7'h40;
  localparam logic [6:0] ADDR_PHASE_B = 7'h41;
  localparam logic [6:0] ADDR_OFFSET_B = 7'h42;
  localparam logic [6:0] ADDR_CRC_A = 7'h69;
  localparam logic [6:0] ADDR_CRC_B = 7'h6A;
  localparam logic [6:0] ADDR_REF_A_HOT = 7'h76;
  localparam logic [6:0] ADDR_REF_A_COLD = 7'h77;
  localparam logic [6:0] ADDR_REF_B_HOT = 7'h78;
  localparam logic [6:0] ADDR_REF_B_COLD = 7'h79;
  localparam logic [6:0] ADDR_LOAD_CAL = 7'h7E;
  localparam logic [6:0] ADDR_GUARD = 7'h7F;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_INTERLEAVE = 0;
  localparam int BIT_CAL_SELECT = 3;
  localparam int BIT_TRIGGER_ENABLE = 7;
  localparam int BIT_FULL_SWING = 8;
  localparam int BIT_DELAY_DISABLE = 12;
  localparam int BIT_LOAD_CAL = 0;
  localparam int BIT_GUARD = 0;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [15:0] RESET_CHIP_CONTROL = 16'h0001;
  localparam logic [15:0] RESET_DELAY = 16'h1000;
  localparam logic [15:0] RESET_GAIN = 16'h0200;
  localparam logic [15:0] RESET_PHASE = 16'h0080;
  localparam logic [15:0] RESET_OFFSET = 16'h0100;
  localparam logic [15:0] RESET_GUARD = 16'h0000;
  localparam logic [15:0] MASK_CHIP_CONTROL = 16'h0189;
  localparam logic [15:0] MASK_DELAY = 16'h13FF;
  localparam logic [15:0] MASK_GAIN = 16'h03FF;
  localparam logic [15:0] MASK_PHASE = 16'h00FF;
  localparam logic [15:0] MASK_OFFSET = 16'h01FF;
  localparam logic [15:0] MASK_GUARD = 16'h0001;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // ****************************************
  // Writable register table
  // ****************************************
  localparam int NUM_RW = 10;
  localparam int IDX_CHIP = 0;
  localparam int IDX_DELAY_A = 1;
  localparam int IDX_GAIN_A = 2;
  localparam int IDX_PHASE_A = 3;
  localparam int IDX_OFFSET_A = 4;
  localparam int IDX_DELAY_B = 5;
  localparam int IDX_GAIN_B = 6;
  localparam int IDX_PHASE_B = 7;
  localparam int IDX_OFFSET_B = 8;
  localparam int IDX_GUARD = 9;
  localparam logic [6:0] RW_ADDR [NUM_RW] = '{ADDR_CHIP_CONTROL, ADDR_DELAY_A, ADDR_GAIN_A,
    ADDR_PHASE_A, ADDR_OFFSET_A, ADDR_DELAY_B, ADDR_GAIN_B, ADDR_PHASE_B, ADDR_OFFSET_B,
    ADDR_GUARD};
  localparam logic [15:0] RW_RESET [NUM_RW] = '{RESET_CHIP_CONTROL, RESET_DELAY, RESET_GAIN,
    RESET_PHASE, RESET_OFFSET, RESET_DELAY, RESET_GAIN, RESET_PHASE, RESET_OFFSET, RESET_GUARD};
  localparam logic [15:0] RW_MASK [NUM_RW] = '{MASK_CHIP_CONTROL, MASK_DELAY, MASK_GAIN,
    MASK_PHASE, MASK_OFFSET, MASK_DELAY, MASK_GAIN, MASK_PHASE, MASK_OFFSET, MASK_GUARD};

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic [9:0] gain;
    logic [7:0] phase;
    logic [8:0] offset;
    logic [15:0] ref_crc;
  } factory_set_t;

  typedef struct packed {
    logic delay_disable;
    logic [9:0] delay_value;
    logic [9:0] gain;
    logic [7:0] phase;
    logic [8:0] offset;
  } channel_trim_t;

endpackage

// file: tmr_cell.sv
/*
  Triplicated configuration register with bitwise majority vote.
  Assumes load and refresh are single-cycle strobes of the same clock.
*/
module tmr_cell #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic refresh,
  // Voted value
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] copy_reg [3];
  logic [WIDTH-1:0] copy_next [3];

  if (WIDTH < 1) begin : g_check
    $error("WIDTH must be at least 1");
  end

  // ****************************************
  // Vote and refresh
  // ****************************************
  assign value = (copy_reg[0] & copy_reg[1]) | (copy_reg[1] & copy_reg[2]) |
    (copy_reg[0] & copy_reg[2]);

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (load) begin
        copy_next[i] = load_value;
      end else if (refresh) begin
        copy_next[i] = value;
      end else begin
        copy_next[i] = copy_reg[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (!reset_n) begin
        copy_reg[i] <= RESET_VALUE;
      end else begin
        copy_reg[i] <= copy_next[i];
      end
    end
  end

  refresh_heal_a: assert property (@(posedge clock) disable iff (!reset_n)
    (refresh && !load) |=> (copy_reg[0] == copy_reg[1]) && (copy_reg[1] == copy_reg[2]))
    else $error("refresh left copies unequal");

endmodule // tmr_cell

// file: adc_config_regs_tb.sv
/*
  Self-checking bench for adc_config_regs: serial frames, trims, guard, cal load, sync gating.
  Assumes adc_regs_pkg and the design files are compiled first; bench drives every input.
*/
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end

module adc_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****
  // Signals and model
  // ****
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic serial_clk = 1'b0;
  logic serial_cs_n = 1'b1;
  logic serial_mosi = 1'b0;
  logic sync_trigger_input = 1'b0;
  adc_regs_pkg::factory_set_t [3:0] factory_cal = '0;
  logic serial_miso, serial_miso_oe, timing_reset, clock_interleave_bit, cal_select;
  logic trigger_enable_bit, sync_out_full_swing, radiation_guard_bit;
  adc_regs_pkg::channel_trim_t trim_a, trim_b;
  logic [15:0] m [10];
  logic [15:0] crc [2] = '{16'h0000, 16'h0000};
  logic [15:0] rd;
  int err_count = 0;
  int checks_done = 0;

  always #5 clock = ~clock;

  adc_config_regs u_dut (.clock, .reset_n, .serial_clk, .serial_cs_n, .serial_mosi,
    .serial_miso, .serial_miso_oe, .factory_cal, .sync_trigger_input, .timing_reset,
    .trim_a, .trim_b, .clock_interleave_bit, .cal_select, .trigger_enable_bit,
    .sync_out_full_swing, .radiation_guard_bit);

  // ****
  // Helpers
  // ****
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic frame(input logic rw, input logic [6:0] a, input logic [15:0] d);
    logic [23:0] w;
    w = {rw, a, d};
    serial_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serial_mosi = w[i];
      cyc(2);
      if (i < 16) rd[i] = serial_miso;
      serial_clk = 1'b1;
      cyc(2);
      serial_clk = 1'b0;
    end
    cyc(2);
    `CHK(serial_miso_oe, 1'b1)
    serial_cs_n = 1'b1;
    cyc(2);
    `CHK(serial_miso_oe, 1'b0)
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    frame(1'b0, a, d);
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    frame(1'b1, a, 16'h0000);
    `CHK(rd, e)
  endtask

  task automatic outs();
    `CHK(trim_a, {m[1][12], m[1][9:0], m[2][9:0], m[3][7:0], m[4][8:0]})
    `CHK(trim_b, {m[5][12], m[5][9:0], m[6][9:0], m[7][7:0], m[8][8:0]})
    `CHK({sync_out_full_swing, trigger_enable_bit, cal_select, clock_interleave_bit},
      {m[0][8], m[0][7], m[0][3], m[0][0]})
    `CHK(radiation_guard_bit, m[9][0])
  endtask

  function automatic logic [15:0] crc_of(logic [26:0] d);
    logic [15:0] c;
    c = adc_regs_pkg::CRC_INIT;
    for (int i = 26; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? adc_regs_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  task automatic load(bit take);
    int s;
    wr(adc_regs_pkg::ADDR_LOAD_CAL, 16'h0001);
    if (take) begin
      for (int ch = 0; ch < 2; ch++) begin
        s = ch * 2 + int'(m[0][3]);
        m[2 + ch * 4] = {6'h00, factory_cal[s].gain};
        m[3 + ch * 4] = {8'h00, factory_cal[s].phase};
        m[4 + ch * 4] = {7'h00, factory_cal[s].offset};
        crc[ch] = crc_of({factory_cal[s].gain, factory_cal[s].phase, factory_cal[s].offset});
      end
    end
  endtask

  task automatic pulse(logic e);
    sync_trigger_input = 1'b1;
    cyc(1);
    sync_trigger_input = 1'b0;
    `CHK(timing_reset, e)
    cyc(1);
    `CHK(timing_reset, 1'b0)
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****
  // Hang guard
  // ****
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    int idx;
    logic [15:0] v;
    void'($urandom(63429));
    for (int i = 0; i < 10; i++) m[i] = adc_regs_pkg::RW_RESET[i];
    cyc(3);
    reset_n = 1'b1;
    cyc(1);
    // Reset values
    outs();
    for (int i = 0; i < 10; i++) begin
      rdchk(adc_regs_pkg::RW_ADDR[i], m[i]);
    end
    // Field boundaries, then random traffic
    for (int k = 0; k < 42; k++) begin
      idx = (k < 18) ? k % 9 : $urandom_range(8, 0);
      v = (k < 9) ? 16'hFFFF : (k < 18) ? 16'h0000 : 16'($urandom);
      if (idx == 1 || idx == 5) v[12] = 1'b1;
      wr(adc_regs_pkg::RW_ADDR[idx], v);
      m[idx] = v & adc_regs_pkg::RW_MASK[idx];
      rdchk(adc_regs_pkg::RW_ADDR[idx], m[idx]);
      outs();
    end
    // Fine delay enabled on both channels together
    m[1] = 16'h0155;
    m[5] = 16'h02AA;
    wr(adc_regs_pkg::ADDR_DELAY_A, m[1]);
    wr(adc_regs_pkg::ADDR_DELAY_B, m[5]);
    outs();
    // Read-only and unmapped places
    wr(adc_regs_pkg::ADDR_CRC_A, 16'hFFFF);
    rdchk(adc_regs_pkg::ADDR_CRC_A, 16'h0000);
    rdchk(7'h10, 16'h0000);
    // Calibration load, both sets
    for (int sel = 0; sel < 2; sel++) begin
      for (int k = 0; k < 4; k++) factory_cal[k] = 43'({$urandom, $urandom});
      m[0] = 16'h0001 | (16'(sel) << 3);
      wr(adc_regs_pkg::ADDR_CHIP_CONTROL, m[0]);
      load(1'b1);
      outs();
      rdchk(adc_regs_pkg::ADDR_CRC_A, crc[0]);
      rdchk(adc_regs_pkg::ADDR_CRC_B, crc[1]);
      for (int k = 0; k < 4; k++) begin
        rdchk(adc_regs_pkg::ADDR_REF_A_HOT + 7'(k), factory_cal[k].ref_crc);
      end
      wr(adc_regs_pkg::ADDR_REF_A_HOT, 16'h0000);
      rdchk(adc_regs_pkg::ADDR_REF_A_HOT, factory_cal[0].ref_crc);
    end
    // Sync gating by mode
    pulse(1'b1);
    m[0] = 16'h0081;
    wr(adc_regs_pkg::ADDR_CHIP_CONTROL, m[0]);
    pulse(1'b0);
    m[0] = 16'h0001;
    wr(adc_regs_pkg::ADDR_CHIP_CONTROL, m[0]);
    // Guard set: sync masked, writes and load dropped, clocking refreshes
    m[9] = 16'h0001;
    wr(adc_regs_pkg::ADDR_GUARD, m[9]);
    pulse(1'b0);
    for (int i = 0; i < 9; i++) wr(adc_regs_pkg::RW_ADDR[i], ~m[i]);
    factory_cal[0] = 43'({$urandom, $urandom});
    load(1'b0);
    outs();
    for (int i = 0; i < 10; i++) begin
      rdchk(adc_regs_pkg::RW_ADDR[i], m[i]);
    end
    rdchk(adc_regs_pkg::ADDR_CRC_A, crc[0]);
    // Guard cleared before reconfiguring and synchronizing
    m[9] = 16'h0000;
    wr(adc_regs_pkg::ADDR_GUARD, m[9]);
    pulse(1'b1);
    m[2] = 16'h0155;
    wr(adc_regs_pkg::ADDR_GAIN_A, m[2]);
    outs();
    load(1'b1);
    rdchk(adc_regs_pkg::ADDR_CRC_A, crc[0]);
    report_and_stop();
  end
endmodule // adc_config_regs_tb
